/* File: core/apc_adc_ctrl.v */
// Purpose: Converter control, power-mode start handling and register map
// Assumes: Wishbone classic slave, 32-bit data, low byte used
// Notes:   Comparator is a pin input, synchronised here
`timescale 1ns/100ps
`include "apc_consts.vh"

module apc_adc_ctrl #(
  parameter W      = 10,
  parameter RC_CYC = `APC_RC_TAD_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [5:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Device state
  input  wire        sleep_i,
  input  wire        cmp_i,
  // Analog control
  output reg  [3:0]  channel_o,
  output reg  [1:0]  vref_o,
  output reg         sampling_o,
  output reg  [15:0] analog_sel_o,
  output reg  [W-1:0] dac_o,
  output reg         cal_active_o,
  output reg         done_irq_o
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam S_IDLE  = 5'b00001;
  localparam S_DEFER = 5'b00010;
  localparam S_ACQ   = 5'b00100;
  localparam S_CONV  = 5'b01000;
  localparam S_WAIT  = 5'b10000;

  reg  [7:0]  ctrl0_r;
  reg  [7:0]  ctrl1_r;
  reg  [7:0]  ancfg0_r;
  reg  [7:0]  ancfg1_r;
  reg  [7:0]  wdt_r;
  reg  [7:0]  osc_r;
  reg  [7:0]  res_hi_r;
  reg  [7:0]  res_lo_r;
  reg  [W-1:0] cal_ofs_r;
  reg  [4:0]  state_r;
  reg  [4:0]  tads_r;
  reg  [2:0]  defer_r;
  reg         flag_r;
  reg         cmp_s1_r;
  reg         cmp_s2_r;
  reg         slp_s1_r;
  reg         slp_s2_r;
  wire        tick;
  wire [W-1:0] trial;
  wire        wr;
  wire        shr;
  wire        go_set;
  wire        go_clr;
  wire        done;
  wire [W-1:0] corr;
  reg  [4:0]  acq_tads;

  function [4:0] acq_len;
    input [2:0] f;
    begin
      case (f)
        3'b001:  acq_len = 5'd2;
        3'b010:  acq_len = 5'd4;
        3'b011:  acq_len = 5'd6;
        3'b100:  acq_len = 5'd8;
        3'b101:  acq_len = 5'd12;
        3'b110:  acq_len = 5'd16;
        3'b111:  acq_len = 5'd20;
        default: acq_len = 5'd0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Sub-blocks
  // ------------------------------------------------------------
  apc_tad_gen #(.RC_CYC(RC_CYC)) u_tad (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (state_r != S_IDLE),
    .clk_sel_i (slp_s2_r ? 3'b011 : ctrl1_r[2:0]),
    .tick_o    (tick)
  );

  apc_sar_step #(.W(W)) u_sar (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (state_r != S_CONV),
    .step_i  (tick && (state_r == S_CONV)),
    .cmp_i   (cmp_s2_r),
    .trial_o (trial)
  );

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign wr     = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
  assign shr    = wdt_r[`APC_SHR_BIT];
  assign go_set = wr && (adr_i == `APC_OFS_CTRL0_ANCFG0) && !shr
                  && dat_i[`APC_C0_GO] && ctrl0_r[`APC_C0_ON];
  assign go_clr = wr && (adr_i == `APC_OFS_CTRL0_ANCFG0) && !shr && !dat_i[`APC_C0_GO];
  assign done   = (state_r == S_CONV) && tick && (tads_r == `APC_CONV_TADS - 1);
  assign corr   = trial - cal_ofs_r;

  // Sleep may only raise RC use; any clock selection is forced to RC (3'b011) while asleep
  always @* begin
    acq_tads = acq_len(ctrl1_r[5:3]);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o  <= 1'b0;
      dat_o  <= 32'h0000_0000;
    end else begin
      ack_o  <= cyc_i && stb_i && !ack_o;
      dat_o  <= 32'h0000_0000;
      case (adr_i)
        `APC_OFS_RES_HIGH:     dat_o[7:0] <= res_hi_r;
        `APC_OFS_RES_LOW:      dat_o[7:0] <= res_lo_r;
        `APC_OFS_CTRL0_ANCFG0: dat_o[7:0] <= shr ? (ancfg0_r & `APC_ANCFG0_MASK)
                                                 : ctrl0_r;
        `APC_OFS_CTRL1_ANCFG1: dat_o[7:0] <= shr ? (ancfg1_r & `APC_ANCFG1_MASK)
                                                 : ctrl1_r;
        `APC_OFS_WDT_CTRL:     dat_o[7:0] <= wdt_r;
        `APC_OFS_OSC_CTRL:     dat_o[7:0] <= osc_r;
        `APC_OFS_STATUS:       dat_o[7:0] <= {2'b00, state_r, flag_r};
        default:               dat_o[7:0] <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers and conversion sequence
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_r   <= `APC_CTRL0_RST;
      ctrl1_r   <= `APC_CTRL1_RST;
      ancfg0_r  <= `APC_ANCFG_RST;
      ancfg1_r  <= `APC_ANCFG_RST;
      wdt_r     <= 8'h00;
      osc_r     <= 8'h00;
      res_hi_r  <= 8'h00;
      res_lo_r  <= 8'h00;
      cal_ofs_r <= {W{1'b0}};
      state_r   <= S_IDLE;
      tads_r    <= 5'd0;
      defer_r   <= 3'd0;
      flag_r    <= 1'b0;
    end else begin
      if (wr) begin
        case (adr_i)
          `APC_OFS_RES_HIGH: res_hi_r <= dat_i[7:0];
          `APC_OFS_RES_LOW:  res_lo_r <= dat_i[7:0];
          `APC_OFS_CTRL0_ANCFG0:
            if (shr) ancfg0_r <= dat_i[7:0] & `APC_ANCFG0_MASK;
            else ctrl0_r <= {dat_i[7:2], ctrl0_r[`APC_C0_GO], dat_i[0]};
          `APC_OFS_CTRL1_ANCFG1:
            if (shr) ancfg1_r <= dat_i[7:0] & `APC_ANCFG1_MASK;
            else ctrl1_r <= dat_i[7:0];
          `APC_OFS_WDT_CTRL: wdt_r <= dat_i[7:0];
          `APC_OFS_OSC_CTRL: osc_r <= dat_i[7:0];
          `APC_OFS_STATUS:   flag_r <= dat_i[0] & flag_r;
          default: ;
        endcase
      end
      if (done)
        flag_r <= 1'b1;
      case (state_r)
        S_IDLE: begin
          tads_r <= 5'd0;
          if (go_set) begin
            ctrl0_r[`APC_C0_GO] <= 1'b1;
            if (acq_tads == 5'd0) begin
              defer_r <= 3'd0;
              state_r <= S_DEFER;
            end else
              state_r <= S_ACQ;
          end
        end
        S_DEFER: begin
          defer_r <= defer_r + 3'd1;
          if (defer_r == `APC_INSTR_CYCLES - 1)
            state_r <= S_CONV;
        end
        S_ACQ:
          if (tick) begin
            tads_r <= tads_r + 5'd1;
            if (tads_r == acq_tads - 5'd1) begin
              tads_r  <= 5'd0;
              state_r <= S_CONV;
            end
          end
        S_CONV:
          if (tick) begin
            tads_r <= tads_r + 5'd1;
            if (done) begin
              tads_r  <= 5'd0;
              ctrl0_r[`APC_C0_GO] <= 1'b0;
              state_r <= S_WAIT;
              if (ctrl1_r[`APC_C1_CAL])
                cal_ofs_r <= trial;
              else if (ctrl1_r[`APC_C1_FMT])
                {res_hi_r, res_lo_r} <= {{(16-W){1'b0}}, corr};
              else
                {res_hi_r, res_lo_r} <= {corr, {(16-W){1'b0}}};
            end
          end
        S_WAIT:
          if (tick) begin
            tads_r <= tads_r + 5'd1;
            if (tads_r == `APC_WAIT_TADS - 1)
              state_r <= S_IDLE;
          end
        default: state_r <= S_IDLE;
      endcase
      // Abort by software or converter off; result is not updated unless the abort falls in the same cycle as done
      if ((go_clr || !ctrl0_r[`APC_C0_ON]) && (state_r != S_IDLE) && (state_r != S_WAIT)) begin
        ctrl0_r[`APC_C0_GO] <= 1'b0;
        tads_r  <= 5'd0;
        state_r <= S_WAIT;
      end
    end
  end

  // ------------------------------------------------------------
  // Synchronisers and outputs
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_s1_r     <= 1'b0;
      cmp_s2_r     <= 1'b0;
      slp_s1_r     <= 1'b0;
      slp_s2_r     <= 1'b0;
      channel_o    <= 4'h0;
      vref_o       <= 2'b00;
      sampling_o   <= 1'b0;
      analog_sel_o <= 16'h0000;
      dac_o        <= {W{1'b0}};
      cal_active_o <= 1'b0;
      done_irq_o   <= 1'b0;
    end else begin
      cmp_s1_r     <= cmp_i;
      cmp_s2_r     <= cmp_s1_r;
      slp_s1_r     <= sleep_i;
      slp_s2_r     <= slp_s1_r;
      channel_o    <= ctrl0_r[5:2];
      vref_o       <= ctrl0_r[7:6];
      // Sampling resumes after completion
      sampling_o   <= ctrl0_r[`APC_C0_ON] && ((state_r == S_IDLE) || (state_r == S_ACQ));
      analog_sel_o <= {ancfg1_r[7:2], 2'b00, ancfg0_r[7], 2'b00, ancfg0_r[4:0]};
      dac_o        <= trial;
      cal_active_o <= ctrl1_r[`APC_C1_CAL] && (state_r == S_CONV);
      done_irq_o   <= flag_r;
    end
  end

endmodule // apc_adc_ctrl

/* File: core/apc_consts.vh */
// Purpose: Constants for the converter power-mode control and register map
// Assumes: Wishbone byte addressing, one register per aligned 32-bit word
// Notes:   Offsets are byte addresses
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define APC_OFS_RES_HIGH      6'h00
`define APC_OFS_RES_LOW       6'h04
`define APC_OFS_CTRL0_ANCFG0  6'h08
`define APC_OFS_CTRL1_ANCFG1  6'h0c
`define APC_OFS_WDT_CTRL      6'h10
`define APC_OFS_OSC_CTRL      6'h14
`define APC_OFS_STATUS        6'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define APC_SHR_BIT           4
`define APC_IDLE_BIT          7
`define APC_C0_ON             0
`define APC_C0_GO             1
`define APC_C1_FMT            7
`define APC_C1_CAL            6

// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define APC_CTRL0_RST         8'h00
`define APC_CTRL1_RST         8'h00
`define APC_ANCFG0_MASK       8'h9f
`define APC_ANCFG1_MASK       8'hfc
`define APC_ANCFG_RST         8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define APC_CONV_TADS         11
`define APC_WAIT_TADS         2
`define APC_INSTR_CYCLES      4
`define APC_RC_TAD_NS         4000
`define APC_CLK_NS            5
`define APC_RC_TAD_CYC        (`APC_RC_TAD_NS / `APC_CLK_NS)

`endif

/* File: core/apc_tad_gen.v */
// Purpose: Conversion clock period tick generator
// Assumes: Clock field encodes divide of the oscillator, x11 selects RC
// Notes:   Tick is one cycle wide, restarts when run is low
`timescale 1ns/100ps
`include "apc_consts.vh"

module apc_tad_gen #(
  parameter RC_CYC = `APC_RC_TAD_CYC
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Control
  input  wire       run_i,
  input  wire [2:0] clk_sel_i,
  // Tick
  output reg        tick_o
);

  reg  [15:0] cnt_r;
  reg  [15:0] lim;

  // ------------------------------------------------------------
  // Divide selection
  // ------------------------------------------------------------
  always @* begin
    case (clk_sel_i)
      3'b000:  lim = 16'h0001;
      3'b100:  lim = 16'h0003;
      3'b001:  lim = 16'h0007;
      3'b101:  lim = 16'h000f;
      3'b010:  lim = 16'h001f;
      3'b110:  lim = 16'h003f;
      default: lim = RC_CYC[15:0] - 16'h0001;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_r  <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_r >= lim) begin
      cnt_r  <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule // apc_tad_gen

/* File: core/apc_sar_step.v */
// Purpose: Successive approximation bit stepper
// Assumes: Comparator input already synchronised
// Notes:   Ten bit result, MSB first, one bit per step
`timescale 1ns/100ps

module apc_sar_step #(
  parameter W = 10
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // Control
  input  wire         clear_i,
  input  wire         step_i,
  input  wire         cmp_i,
  // Trial value and result
  output reg  [W-1:0] trial_o
);

  reg  [W-1:0] mask_r;

  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      mask_r  <= {1'b1, {(W-1){1'b0}}};
      trial_o <= {1'b1, {(W-1){1'b0}}};
    end else if (step_i && (mask_r != {W{1'b0}})) begin
      mask_r  <= mask_r >> 1;
      trial_o <= (cmp_i ? trial_o : (trial_o & ~mask_r)) | (mask_r >> 1);
    end
  end

endmodule // apc_sar_step

/* File: tb/apc_checker.sv */
// Purpose: Port assertions for apc_adc_ctrl
// Assumes: Classic Wishbone, one access per ack
// Notes:   Bank select is shadowed from bus writes
`timescale 1ns/100ps

module apc_checker (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Bus
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [5:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  // Converter
  input wire [3:0]  channel_o,
  input wire [1:0]  vref_o,
  input wire        sampling_o,
  input wire        cal_active_o,
  input wire        done_irq_o
);
  // --------------------
  // Shadow state
  // --------------------
  wire      take = cyc_i & stb_i & !ack_o;
  wire      wr   = take & we_i & sel_i[0];
  reg       shr_r;
  reg [7:0] c0_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      shr_r <= 1'b0;
      c0_r  <= 8'h00;
    end else begin
      if (wr && adr_i == 6'h10) shr_r <= dat_i[4];
      if (wr && adr_i == 6'h08 && !shr_r) c0_r <= dat_i[7:0];
    end
  end

  // --------------------
  // Assertions
  // --------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack wider than one cycle");
  a_ack_latency: assert property (take |=> ack_o) else $error("ack late");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_high_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000) else $error("upper read bits set");
  a_unmapped_zero: assert property (take && !we_i && adr_i >= 6'h1c |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_cfg0_holes: assert property (take && !we_i && shr_r && adr_i == 6'h08 |=> dat_o[6:5] == 2'b00)
    else $error("config zero holes set");
  a_cfg1_holes: assert property (take && !we_i && shr_r && adr_i == 6'h0c |=> dat_o[1:0] == 2'b00)
    else $error("config one holes set");
  a_chan_follow: assert property (wr && adr_i == 6'h08 && !shr_r |-> ##2
    (channel_o == c0_r[5:2] && vref_o == c0_r[7:6])) else $error("channel or reference stale");
  a_done_resample: assert property ($rose(done_irq_o) |-> ##[0:200] sampling_o)
    else $error("no sampling after done");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
    (!ack_o && !done_irq_o && !sampling_o && !cal_active_o && channel_o == 4'h0)) else $error("reset left outputs");

  cover property ($rose(done_irq_o));
  cover property ($fell(cal_active_o));
  cover property (take && shr_r && adr_i == 6'h0c);
endmodule // apc_checker

/* File: tb/adc_power_mode_control_and_map_test.sv */
// Purpose: Self-checking bench for apc_adc_ctrl
// Assumes: RC period cut to 4 cycles, comparator held high
// Notes:   Reads note expectations in a queue for the monitor
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module adc_power_mode_control_and_map_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, sleep_i = 1'b0, cmp_i = 1'b1;
  logic [5:0]  adr_i = 6'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rdat, v;
  logic        ack_o, sampling_o, cal_active_o, done_irq_o;
  logic [3:0]  channel_o;
  logic [1:0]  vref_o;
  logic [15:0] analog_sel_o;
  logic [63:0] q[$];
  logic [63:0] nt;
  logic [31:0] seed = 32'h8109b997;
  int          error_cnt = 0, compares = 0, cyc_n = 0;
  int          dv_tab[7] = '{2, 4, 8, 16, 32, 64, 4};
  logic [2:0]  cs_tab[7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};

  apc_adc_ctrl #(.RC_CYC(4)) dut (.*, .dac_o());

  initial forever #2.5 clk_i = ~clk_i;

  // --------------------
  // Tasks
  // --------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hold the request until ack is sampled, then a gap cycle
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [31:0] m,
                     input logic [31:0] e);
    q.push_back({m, e});
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h1, 24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= 3'b000;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'b0, a, 8'h00, m, e);
  endtask

  task automatic conv(input logic [2:0] cs, input int dv, input logic f, input logic [2:0] aq);
    int t;
    sleep_i <= (cs[1:0] == 2'b11);
    wr(6'h14, 8'h00);
    wr(6'h18, 8'h00);
    wr(6'h0c, {f, 1'b0, aq, cs});
    repeat (3 * dv + 10) @(posedge clk_i);
    wr(6'h08, 8'h03);
    t = cyc_n;
    // Status shows deferral or acquisition, not yet converting
    rd(6'h18, 32'h3e, (aq == 3'b000) ? 32'h04 : 32'h08);
    while (done_irq_o !== 1'b1) @(posedge clk_i);
    t = cyc_n - t;
    `CHK("conv cycles", 1'b1, t >= 11 * dv && t <= ((aq == 3'b000) ? 14 : 18) * dv + 12)
    rd(6'h08, 32'h2, 32'h0);
    rd(6'h00, 32'hff, f ? 32'h03 : 32'hff);
    rd(6'h04, 32'hff, f ? 32'hff : 32'hc0);
  endtask

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      rdat = dat_o;
      if (nt[63:32] != 32'h0) `CHK("read data", nt[31:0], dat_o & nt[63:32])
    end
  end

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // --------------------
  // Sequence
  // --------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(6'h08, 32'hff, 32'h0);
    rd(6'h0c, 32'hff, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wr(6'h0c, v[7:0]);
      rd(6'h0c, 32'hff, {24'h0, v[7:0]});
      wr(6'h08, v[15:8] & 8'hfc);
      rd(6'h08, 32'hff, {24'h0, v[15:8] & 8'hfc});
      `CHK("channel", v[13:10], channel_o)
    end
    wr(6'h10, 8'h10);
    wr(6'h08, 8'hff);
    rd(6'h08, 32'hff, 32'h9f);
    wr(6'h0c, 8'hff);
    rd(6'h0c, 32'hff, 32'hfc);
    `CHK("analog select", 16'hfc9f, analog_sel_o)
    wr(6'h08, 8'h00);
    wr(6'h10, 8'h00);
    rd(6'h08, 32'hff, {24'h0, v[15:8] & 8'hfc});
    wr(6'h3c, 8'hff);
    rd(6'h3c, 32'hffffffff, 32'h0);
    wr(6'h08, 8'h01);
    for (int i = 0; i < 7; i++) begin
      v = rnd();
      conv(cs_tab[i], dv_tab[i], v[0], i[0] ? 3'b010 : 3'b000);
    end
    wr(6'h10, 8'h10);
    wr(6'h08, 8'h9e);
    wr(6'h10, 8'h00);
    wr(6'h0c, 8'h43);
    wr(6'h08, 8'h03);
    repeat (8) @(posedge clk_i);
    `CHK("cal active", 1'b1, cal_active_o)
    rd(6'h08, 32'h2, 32'h2);
    while (rdat[1] === 1'b1) rd(6'h08, 32'h0, 32'h0);
    `CHK("cal active", 1'b0, cal_active_o)
    wr(6'h0c, 8'h03);
    rd(6'h0c, 32'hff, 32'h03);
    wrap_up();
  end
endmodule // adc_power_mode_control_and_map_test

bind apc_adc_ctrl apc_checker chk (.*);
